// file: frc_pkg.sv
//
// Contract
// [R1] A guarded control bit accepts 1 only right after a write of 0 to it.
// [R2] Software keeps interrupts and DMA out between clearing and setting.
// [R3] With NMI pin function on, guarded bits set only while NMI pin high.
// [R4] NMI reinitialises both control registers and halts any rewrite.
// [R5] Software blocks relocatable and address-match interrupts in ROM mode.
// [R6] Ready flag reads 0 during auto operation; no DMA then in ROM mode.
// [R7] Reset 1, reset 2, NMI or watchdog interrupt abort a running command.
// [R8] After an abort software erases the block before retrying.
// [R9] Software programs each address only once per block erase.
// [R10] Block A/B wait select inserts one wait on block A or B accesses.
// [R11] Other blocks and RAM follow only the global wait select.
// [R12] Software selects a wait state once block A or B exceeds 100 cycles.
// [R13] External controller sequences reset and boot-select for boot mode.
// [R14] Ports may be indeterminate while boot-select high and reset low.
// [R15] Port 6 bit 7 pull-up is connected while boot-select high, reset low.
package frc_pkg;
    localparam logic [11:0] FRC_CTRL_A_OFF = 12'h000;
    localparam logic [11:0] FRC_CTRL_B_OFF = 12'h004;
    localparam logic [11:0] FRC_CMD_OFF = 12'h008;
    localparam logic [11:0] FRC_STAT_OFF = 12'h00C;
    // Control register A fields
    localparam int FRC_READY_BIT = 0;
    localparam int FRC_REWRITE_EN_BIT = 1;
    localparam int FRC_LOW_PROT_BIT = 2;
    // Control register B fields
    localparam int FRC_ROM_MODE_BIT = 1;
    localparam int FRC_EXT_PROT_BIT = 6;
    localparam int FRC_AB_WAIT_BIT = 7;
    // Command register fields
    localparam int FRC_CMD_PROG_BIT = 0;
    localparam int FRC_CMD_ERASE_BIT = 1;
    // Status register fields
    localparam int FRC_ABORTED_BIT = 0;
    localparam int FRC_BUSY_BIT = 1;
    localparam logic [7:0] FRC_CTRL_A_RST = 8'h01;
    localparam logic [7:0] FRC_CTRL_B_RST = 8'h00;
    // Length of an auto operation in clock cycles
    localparam logic [7:0] FRC_PROG_CYCLES = 8'h20;
    localparam logic [7:0] FRC_ERASE_CYCLES = 8'hC0;
endpackage

// file: frc_top.sv
`timescale 1ns/10ps
module frc_top (
    input wire logic mclk_i, // 25 MHz clock
    input wire logic resetn_i, // Async reset, active low
    input wire logic psel_i, // APB select
    input wire logic penable_i, // APB enable
    input wire logic pwrite_i, // APB direction
    input wire logic [11:0] paddr_i, // APB byte address
    input wire logic [31:0] pwdata_i, // APB write data
    output logic [31:0] prdata_o, // APB read data
    output logic pready_o, // APB ready
    output logic pslverr_o, // APB error
    input wire logic nmi_pin_i, // NMI pin level, high when idle
    input wire logic nmi_int_i, // NMI accepted, pulse
    input wire logic wdt_int_i, // Watchdog interrupt, pulse
    input wire logic hw_reset2_i, // Hardware reset 2, pulse
    input wire logic nmi_pin_function_select_i, // NMI pin function on
    input wire logic global_wait_select_i, // Global wait select
    input wire logic acc_valid_i, // Flash or RAM access request
    input wire logic acc_block_ab_i, // Access targets block A or B
    output logic acc_wait_o, // Insert one wait on this access
    input wire logic boot_select_pin_i, // Boot-select pin level
    input wire logic reset_pin_i, // Reset pin level
    output logic port6_bit7_pullup_o, // Pull-up on port 6 bit 7
    output logic port_hold_undef_o, // Ports may be indeterminate
    output logic cpu_rewrite_enable_o, // Rewrite enable bit
    output logic rom_resident_rewrite_mode_o // ROM-resident mode active
);
    typedef enum logic [1:0] {FRC_IDLE, FRC_PROG, FRC_ERASE} frc_state_t;
    frc_state_t state_reg, state_next;
    logic [7:0] ctrl_a_reg, ctrl_b_reg, last_a_reg, last_b_reg;
    logic [7:0] cnt_reg, cnt_next;
    logic aborted_reg, prev_wr_a_reg, prev_wr_b_reg;
    logic [31:0] prdata_reg;

    // Bus decode
    wire acc_ph = psel_i && penable_i;
    wire wr = acc_ph && pwrite_i;
    wire hit_a = paddr_i == frc_pkg::FRC_CTRL_A_OFF;
    wire hit_b = paddr_i == frc_pkg::FRC_CTRL_B_OFF;
    wire hit_c = paddr_i == frc_pkg::FRC_CMD_OFF;
    wire hit_s = paddr_i == frc_pkg::FRC_STAT_OFF;
    wire mapped = hit_a || hit_b || hit_c || hit_s;
    wire wr_a = wr && hit_a;
    wire wr_b = wr && hit_b;
    wire any_wr = wr && mapped;
    // Halting events clear control and stop a running command
    wire halt = nmi_int_i || wdt_int_i || hw_reset2_i; // [R4] [R7]
    // NMI pin low while its function is on blocks setting guarded bits
    wire set_ok = !nmi_pin_function_select_i || nmi_pin_i; // [R3]
    wire busy = state_reg != FRC_IDLE;

    // Guarded bit: 1 accepted only if the previous bus write cleared it
    function automatic logic guard(input logic cur, input logic nw,
                                   input logic prev_wr, input logic last,
                                   input logic ok);
        guard = nw ? (cur | (prev_wr && !last && ok)) : 1'b0; // [R1] [R3]
    endfunction

    wire [7:0] wa = pwdata_i[7:0];
    wire [7:0] a_next = {ctrl_a_reg[7:3],
        guard(ctrl_a_reg[frc_pkg::FRC_LOW_PROT_BIT],
              wa[frc_pkg::FRC_LOW_PROT_BIT], prev_wr_a_reg,
              last_a_reg[frc_pkg::FRC_LOW_PROT_BIT], set_ok),
        guard(ctrl_a_reg[frc_pkg::FRC_REWRITE_EN_BIT],
              wa[frc_pkg::FRC_REWRITE_EN_BIT], prev_wr_a_reg,
              last_a_reg[frc_pkg::FRC_REWRITE_EN_BIT], set_ok),
        ctrl_a_reg[0]}; // [R1]
    wire [7:0] b_next = {wa[frc_pkg::FRC_AB_WAIT_BIT],
        guard(ctrl_b_reg[frc_pkg::FRC_EXT_PROT_BIT],
              wa[frc_pkg::FRC_EXT_PROT_BIT], prev_wr_b_reg,
              last_b_reg[frc_pkg::FRC_EXT_PROT_BIT], set_ok),
        4'h0,
        guard(ctrl_b_reg[frc_pkg::FRC_ROM_MODE_BIT],
              wa[frc_pkg::FRC_ROM_MODE_BIT], prev_wr_b_reg,
              last_b_reg[frc_pkg::FRC_ROM_MODE_BIT], set_ok),
        1'b0}; // [R1]
    // Command start needs rewrite enabled and no command running
    wire start_ok = wr && hit_c && !busy &&
        ctrl_a_reg[frc_pkg::FRC_REWRITE_EN_BIT];
    wire start_p = start_ok && pwdata_i[frc_pkg::FRC_CMD_PROG_BIT];
    wire start_e = start_ok && !pwdata_i[frc_pkg::FRC_CMD_PROG_BIT] &&
        pwdata_i[frc_pkg::FRC_CMD_ERASE_BIT];

    // Command sequencer
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        if (halt) begin
            state_next = FRC_IDLE; // [R7]
            cnt_next = 8'h00;
        end else begin
            unique case (state_reg)
                FRC_IDLE: begin
                    if (start_p) begin
                        state_next = FRC_PROG;
                        cnt_next = frc_pkg::FRC_PROG_CYCLES;
                    end else if (start_e) begin
                        state_next = FRC_ERASE;
                        cnt_next = frc_pkg::FRC_ERASE_CYCLES;
                    end
                end
                FRC_PROG, FRC_ERASE: begin
                    cnt_next = cnt_reg - 8'h01;
                    if (cnt_reg == 8'h01)
                        state_next = FRC_IDLE;
                end
            endcase
        end
    end

    // Read mux; ready flag shows the sequencer, not a stored bit
    wire [7:0] a_rd = {ctrl_a_reg[7:1], !busy}; // [R6]
    wire [31:0] rd_mux = hit_a ? {24'h000000, a_rd} :
        hit_b ? {24'h000000, ctrl_b_reg} :
        hit_s ? {30'h0, busy, aborted_reg} : 32'h00000000;
    wire abort_ev = halt && busy;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= FRC_IDLE;
            cnt_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // Control registers; halt reinitialises both
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_a_reg <= frc_pkg::FRC_CTRL_A_RST;
            ctrl_b_reg <= frc_pkg::FRC_CTRL_B_RST;
        end else if (halt) begin
            ctrl_a_reg <= frc_pkg::FRC_CTRL_A_RST; // [R4]
            ctrl_b_reg <= frc_pkg::FRC_CTRL_B_RST; // [R4]
        end else begin
            if (wr_a)
                ctrl_a_reg <= a_next;
            if (wr_b)
                ctrl_b_reg <= b_next;
        end
    end

    // Last written value and whether the previous write hit the same reg
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            last_a_reg <= 8'hFF;
            last_b_reg <= 8'hFF;
            prev_wr_a_reg <= 1'b0;
            prev_wr_b_reg <= 1'b0;
        end else if (halt) begin
            prev_wr_a_reg <= 1'b0;
            prev_wr_b_reg <= 1'b0;
        end else if (any_wr) begin
            prev_wr_a_reg <= wr_a; // [R1]
            prev_wr_b_reg <= wr_b;
            if (wr_a)
                last_a_reg <= wa;
            if (wr_b)
                last_b_reg <= wa;
        end
    end

    // Abort flag: a new abort wins over a software clear
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i)
            aborted_reg <= 1'b0;
        else if (abort_ev)
            aborted_reg <= 1'b1; // [R7]
        else if (wr && hit_s && pwdata_i[frc_pkg::FRC_ABORTED_BIT])
            aborted_reg <= 1'b0;
    end

    // Bus answers in the first access cycle, registered read data
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prdata_reg <= 32'h00000000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            prdata_reg <= rd_mux;
            pready_o <= psel_i && !pready_o;
            pslverr_o <= psel_i && !pready_o && !mapped;
        end
    end
    assign prdata_o = prdata_reg;

    // Wait state and pin outputs, registered one cycle
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            acc_wait_o <= 1'b0;
            port6_bit7_pullup_o <= 1'b0;
            port_hold_undef_o <= 1'b0;
            cpu_rewrite_enable_o <= 1'b0;
            rom_resident_rewrite_mode_o <= 1'b0;
        end else begin
            acc_wait_o <= acc_valid_i && ((acc_block_ab_i &&
                ctrl_b_reg[frc_pkg::FRC_AB_WAIT_BIT]) || // [R10]
                global_wait_select_i); // [R11]
            port6_bit7_pullup_o <= boot_select_pin_i && !reset_pin_i; // [R15]
            port_hold_undef_o <= boot_select_pin_i && !reset_pin_i; // [R14]
            cpu_rewrite_enable_o <= ctrl_a_reg[frc_pkg::FRC_REWRITE_EN_BIT];
            rom_resident_rewrite_mode_o <=
                ctrl_a_reg[frc_pkg::FRC_REWRITE_EN_BIT] &&
                ctrl_b_reg[frc_pkg::FRC_ROM_MODE_BIT];
        end
    end

    // Guarded set steps: the clearing write, then the setting write
    sequence s_clear_a;
        wr_a && !halt && !wa[frc_pkg::FRC_REWRITE_EN_BIT];
    endsequence
    sequence s_set_a;
        wr_a && !halt && set_ok && wa[frc_pkg::FRC_REWRITE_EN_BIT];
    endsequence
    a_guard_set_needs_clear: assert property (@(posedge mclk_i) // [R1]
        disable iff (!resetn_i) $rose(ctrl_a_reg[frc_pkg::FRC_REWRITE_EN_BIT])
        |-> $past(prev_wr_a_reg)) else $error("set without clear");
    // Back-to-back bus writes leave two idle cycles between the pair
    a_guard_clear_set: assert property (@(posedge mclk_i) // [R1]
        disable iff (!resetn_i) s_clear_a ##1 (!any_wr && !halt)[*2]
        ##1 s_set_a |=> ctrl_a_reg[frc_pkg::FRC_REWRITE_EN_BIT])
        else $error("clear then set refused");
    a_nmi_pin_block: assert property (@(posedge mclk_i) // [R3]
        disable iff (!resetn_i) (wr_a && !set_ok &&
        !ctrl_a_reg[frc_pkg::FRC_REWRITE_EN_BIT])
        |=> !ctrl_a_reg[frc_pkg::FRC_REWRITE_EN_BIT])
        else $error("set with nmi low");
    a_halt_reinit: assert property (@(posedge mclk_i) // [R4]
        disable iff (!resetn_i) halt |=> (ctrl_a_reg ==
        frc_pkg::FRC_CTRL_A_RST && ctrl_b_reg == frc_pkg::FRC_CTRL_B_RST))
        else $error("halt did not reinit");
    a_ready_busy: assert property (@(posedge mclk_i) // [R6]
        disable iff (!resetn_i) start_p && !halt |=> (busy && !a_rd[0])[*8])
        else $error("ready not low");
    a_abort_cmd: assert property (@(posedge mclk_i) // [R7]
        disable iff (!resetn_i) halt && busy |=> !busy && aborted_reg)
        else $error("command not aborted");
    a_ab_wait: assert property (@(posedge mclk_i) // [R10]
        disable iff (!resetn_i) acc_valid_i && acc_block_ab_i &&
        ctrl_b_reg[frc_pkg::FRC_AB_WAIT_BIT] |=> acc_wait_o)
        else $error("no block ab wait");
    a_other_wait: assert property (@(posedge mclk_i) // [R11]
        disable iff (!resetn_i) acc_valid_i && !acc_block_ab_i
        |=> acc_wait_o == $past(global_wait_select_i))
        else $error("other wait wrong");
    a_boot_pullup: assert property (@(posedge mclk_i) // [R14] [R15]
        disable iff (!resetn_i) boot_select_pin_i && !reset_pin_i
        |=> port6_bit7_pullup_o && port_hold_undef_o)
        else $error("no pull-up");
endmodule

// file: frc_top_tb.sv
`timescale 1ns/10ps
module frc_top_tb;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [31:0] prdata_o, q;
    logic pready_o, pslverr_o, err, acc_wait_o, port6_bit7_pullup_o;
    logic port_hold_undef_o, cpu_rewrite_enable_o, rom_resident_rewrite_mode_o;
    logic nmi_pin_i = 1'b1, nmi_int_i = 1'b0, wdt_int_i = 1'b0;
    logic hw_reset2_i = 1'b0, nmi_pin_function_select_i = 1'b0;
    logic global_wait_select_i = 1'b0, acc_valid_i = 1'b0;
    logic acc_block_ab_i = 1'b0, boot_select_pin_i = 1'b0, reset_pin_i = 1'b1;
    int fails = 0;
    int cmp_count = 0;
    frc_top frc_top_inst (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .nmi_pin_i(nmi_pin_i),
        .nmi_int_i(nmi_int_i), .wdt_int_i(wdt_int_i),
        .hw_reset2_i(hw_reset2_i),
        .nmi_pin_function_select_i(nmi_pin_function_select_i),
        .global_wait_select_i(global_wait_select_i),
        .acc_valid_i(acc_valid_i), .acc_block_ab_i(acc_block_ab_i),
        .acc_wait_o(acc_wait_o), .boot_select_pin_i(boot_select_pin_i),
        .reset_pin_i(reset_pin_i), .port6_bit7_pullup_o(port6_bit7_pullup_o),
        .port_hold_undef_o(port_hold_undef_o),
        .cpu_rewrite_enable_o(cpu_rewrite_enable_o),
        .rom_resident_rewrite_mode_o(rom_resident_rewrite_mode_o));
    // Free-running 25 MHz clock
    always #20 mclk_i = ~mclk_i;
    task automatic finish_test();
        if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // APB transfer; the request is held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge mclk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        q = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 20) begin
            fails++;
            finish_test();
        end
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask
    // Guarded set: clear then set, with nothing in between
    task automatic enable_rewrite();
        apb(1'b1, frc_pkg::FRC_CTRL_A_OFF, 32'h0000_0000);
        apb(1'b1, frc_pkg::FRC_CTRL_A_OFF, 32'h0000_0002);
    endtask
    // Polls the ready flag; a bounded count guards against a hang
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            apb(1'b0, frc_pkg::FRC_CTRL_A_OFF, 32'h0000_0000);
            n++;
        end while (q[0] !== 1'b1 && n < 100);
        chk(q, 32'h0000_0003);
        if (q[0] !== 1'b1)
            finish_test();
    endtask
    initial begin
        repeat (16) @(posedge mclk_i);
        resetn_i <= 1'b1;
        rchk(frc_pkg::FRC_CTRL_A_OFF, 32'h0000_0001);
        rchk(frc_pkg::FRC_CTRL_B_OFF, 32'h0000_0000);
        apb(1'b1, frc_pkg::FRC_CTRL_A_OFF, 32'h0000_0002);
        rchk(frc_pkg::FRC_CTRL_A_OFF, 32'h0000_0001);
        // A write to another register between clear and set breaks the pair
        apb(1'b1, frc_pkg::FRC_CTRL_A_OFF, 32'h0000_0000);
        apb(1'b1, frc_pkg::FRC_CTRL_B_OFF, 32'h0000_0000);
        apb(1'b1, frc_pkg::FRC_CTRL_A_OFF, 32'h0000_0006);
        rchk(frc_pkg::FRC_CTRL_A_OFF, 32'h0000_0001);
        // Commands are ignored while rewrite is disabled
        apb(1'b1, frc_pkg::FRC_CMD_OFF, 32'h0000_0001);
        rchk(frc_pkg::FRC_STAT_OFF, 32'h0000_0000);
        apb(1'b1, frc_pkg::FRC_CTRL_B_OFF, 32'h0000_0000);
        apb(1'b1, frc_pkg::FRC_CTRL_B_OFF, 32'h0000_0042);
        rchk(frc_pkg::FRC_CTRL_B_OFF, 32'h0000_0042);
        // ROM-resident mode is only active once rewrite is enabled too
        chk(rom_resident_rewrite_mode_o, 1'b0);
        // NMI pin function on: setting works only with the pin high
        nmi_pin_function_select_i <= 1'b1;
        nmi_pin_i <= 1'b0;
        enable_rewrite();
        rchk(frc_pkg::FRC_CTRL_A_OFF, 32'h0000_0001);
        nmi_pin_i <= 1'b1;
        enable_rewrite();
        rchk(frc_pkg::FRC_CTRL_A_OFF, 32'h0000_0003);
        chk(cpu_rewrite_enable_o, 1'b1);
        chk(rom_resident_rewrite_mode_o, 1'b1);
        // Erase before program, each address programmed once; only reads of
        // control register A and status run on the bus while busy in ROM-resident mode
        apb(1'b1, frc_pkg::FRC_CMD_OFF, 32'h0000_0002);
        rchk(frc_pkg::FRC_CTRL_A_OFF, 32'h0000_0002);
        wait_ready();
        apb(1'b1, frc_pkg::FRC_CMD_OFF, 32'h0000_0001);
        rchk(frc_pkg::FRC_STAT_OFF, 32'h0000_0002);
        wait_ready();
        // Each halt source aborts a running erase and clears both registers
        for (int h = 0; h < 3; h++) begin
            enable_rewrite();
            apb(1'b1, frc_pkg::FRC_CTRL_B_OFF, 32'h0000_0080);
            apb(1'b1, frc_pkg::FRC_CMD_OFF, 32'h0000_0002);
            @(posedge mclk_i);
            {hw_reset2_i, wdt_int_i, nmi_int_i} <= 3'(1 << h);
            @(posedge mclk_i);
            {hw_reset2_i, wdt_int_i, nmi_int_i} <= 3'b000;
            rchk(frc_pkg::FRC_CTRL_A_OFF, 32'h0000_0001);
            rchk(frc_pkg::FRC_CTRL_B_OFF, 32'h0000_0000);
            rchk(frc_pkg::FRC_STAT_OFF, 32'h0000_0001);
            apb(1'b1, frc_pkg::FRC_STAT_OFF, 32'h0000_0001);
            rchk(frc_pkg::FRC_STAT_OFF, 32'h0000_0000);
        end
        // Reset aborts an erase; the block is erased again before the retry
        enable_rewrite();
        apb(1'b1, frc_pkg::FRC_CMD_OFF, 32'h0000_0002);
        @(posedge mclk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        resetn_i <= 1'b1;
        rchk(frc_pkg::FRC_STAT_OFF, 32'h0000_0000);
        rchk(frc_pkg::FRC_CTRL_A_OFF, 32'h0000_0001);
        enable_rewrite();
        apb(1'b1, frc_pkg::FRC_CMD_OFF, 32'h0000_0002);
        wait_ready();
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk(err, 1'b1);
        // Wait insertion over every select combination
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, frc_pkg::FRC_CTRL_B_OFF, 32'(i[2]) << 7);
            @(posedge mclk_i);
            acc_valid_i <= 1'b1;
            global_wait_select_i <= i[1];
            acc_block_ab_i <= i[0];
            repeat (2) @(posedge mclk_i);
            chk(acc_wait_o, (i[2] & i[0]) | i[1]);
            acc_valid_i <= 1'b0;
        end
        // Boot entry order: both low, boot-select up, then reset released
        for (int b = 0; b < 4; b++) begin
            @(posedge mclk_i);
            boot_select_pin_i <= b[1];
            reset_pin_i <= ~(b[1] ^ b[0]);
            repeat (2) @(posedge mclk_i);
            chk(port6_bit7_pullup_o, b[1] & ~b[0]);
            chk(port_hold_undef_o, b[1] & ~b[0]);
        end
        // Low block protect release is guarded like rewrite enable
        apb(1'b1, frc_pkg::FRC_CTRL_A_OFF, 32'h0000_0000);
        apb(1'b1, frc_pkg::FRC_CTRL_A_OFF, 32'h0000_0006);
        rchk(frc_pkg::FRC_CTRL_A_OFF, 32'h0000_0007);
        finish_test();
    end
endmodule
